// ### hdl/duty_pwm.v
// Free-running PWM generator for the transfer level line.
// Assumes one clock; a duty of all ones holds the output high.
`timescale 1ns/1ps
`default_nettype none

module duty_pwm #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] duty,
  output reg pwmOut
);

  reg [WIDTH-1:0] phase_reg;

  // ****************************************
  // Phase counter and compare
  // ****************************************
  // Full-scale duty pins the output high for zero positive transfer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg <= {WIDTH{1'b0}};
      pwmOut <= 1'b1;
    end else begin
      phase_reg <= phase_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      pwmOut <= (&duty) || (phase_reg < duty);
    end
  end

endmodule

`default_nettype wire

// ### hdl/engine_seq_regs.vh
// Register map, field positions, reset values and timing counts for the
// print engine scan and high-voltage sequencer. Assumes 32-bit AXI4-Lite words.
`ifndef ENGINE_SEQ_REGS_VH
`define ENGINE_SEQ_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_XFER_DUTY 8'h08
`define REG_LEFT_MARGIN 8'h0C
`define REG_LINE_LEN 8'h10
`define REG_VIDEO_DATA 8'h14
`define REG_FUSE_PULSE 8'h18

// ****************************************
// Control fields
// ****************************************
`define CTRL_MOTOR_RUN 0
`define CTRL_XFER_ON 1
`define CTRL_MAIN_ON 2
`define CTRL_SUPPLY_ON 3
`define CTRL_DEV_ON 4
`define CTRL_DEV_HIGH 5
`define CTRL_PRINT_GO 6
`define CTRL_COUNT_CLR_DONE 7

// ****************************************
// Status fields
// ****************************************
`define STAT_READY 0
`define STAT_COVER_OPEN 1
`define STAT_FUSE_INTACT 2
`define STAT_NEW_CART 3
`define STAT_CLEAR_REQ 4
`define STAT_FUSE_BLOWING 5
`define STAT_VIDEO_ACTIVE 6
`define STAT_PAPER_FEED 7

// ****************************************
// Reset values and timing
// ****************************************
`define DUTY_RESET 8'hFF
`define MARGIN_RESET 16'h0040
`define LINE_LEN_RESET 16'h0400
`define FUSE_PULSE_MS 100
`define CLK_HZ 20000000
`define FUSE_PULSE_CYCLES ((`FUSE_PULSE_MS * (`CLK_HZ / 1000)))
`define AXI_OKAY 2'b00
`define AXI_DECERR 2'b11

`endif

// ### hdl/print_engine_seq.v
// Top of the scan and high-voltage sequencer with its AXI4-Lite slave.
// Assumes sensor inputs already synchronous to clk; NVRAM handled by software.
// Operation
// RULE1: Assert motor run line to spin mirror
// RULE2: Scan unit raises ready at constant speed
// RULE3: Scan unit pulses sync once per line
// RULE4: Video aligns its left edge to sync
// RULE5: Laser fires only through video line
// RULE6: On cover open, test cartridge fuse
// RULE7: Intact fuse means new; clear count
// RULE8: Then apply 24V to blow fuse
// RULE9: Transfer enable low activates both sections
// RULE10: PWM held high gives 0V positive
// RULE11: PWM duty sets positive transfer level
// RULE12: Main enable high turns on charge
// RULE13: Supply or developer enable low turns on
// RULE14: Developer level selectable 300V or 350V
// RULE15: Image data only after paper feeding
// RULE16: Hold motor, withhold video until ready
// RULE17: Duty is register; full high zero output
`timescale 1ns/1ps
`include "engine_seq_regs.vh"
`default_nettype none

module print_engine_seq #(
  parameter FUSE_CYCLES = `FUSE_PULSE_CYCLES,
  parameter DUTY_WIDTH = 8
) (
  input wire clk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire scannerReady,
  input wire lineSync,
  input wire coverOpen,
  input wire fuseIntact,
  input wire paperFeed,
  output reg mirrorMotorRun,
  output reg laserVideo,
  output reg transferEnable_n,
  output reg transferLevelPwm,
  output reg mainChargeEnable,
  output reg supplyBiasEnable_n,
  output reg developerBiasEnable_n,
  output reg developerLevelHigh,
  output reg fuseBlowEnable
);

  localparam CART_IDLE = 4'b0001;
  localparam CART_CLEAR = 4'b0010;
  localparam CART_BLOW = 4'b0100;
  localparam CART_WAIT = 4'b1000;

  reg [7:0] ctrl_reg;
  reg [DUTY_WIDTH-1:0] duty_reg;
  reg [15:0] margin_reg;
  reg [15:0] lineLen_reg;
  reg [31:0] videoWord_reg;
  reg [31:0] fuseCount_reg;
  reg [3:0] cart_reg;
  reg newCart_reg;
  reg coverPrev_reg;
  reg syncPrev_reg;
  reg videoActive_reg;
  reg [15:0] pixCount_reg;
  reg [7:0] awAddr_reg;
  reg awHeld_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg wHeld_reg;
  wire pwmRaw;
  wire doWrite;
  wire syncRise;
  wire coverRise;
  wire clrDoneWr;
  reg [31:0] rdMux;
  reg rdHit;

  // ****************************************
  // Transfer PWM
  // ****************************************
  duty_pwm #(
    .WIDTH(DUTY_WIDTH)
  ) xferPwm (
    .clk(clk),
    .rst(rst),
    .duty(duty_reg), // [RULE17]
    .pwmOut(pwmRaw)
  );

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  // Address and data latched independently, either may arrive first
  assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign clrDoneWr = doWrite && (awAddr_reg == `REG_CTRL) && wStrb_reg[0] &&
    wData_reg[`CTRL_COUNT_CLR_DONE];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      ctrl_reg <= 8'h00;
      duty_reg <= {DUTY_WIDTH{1'b1}};
      margin_reg <= `MARGIN_RESET;
      lineLen_reg <= `LINE_LEN_RESET;
      videoWord_reg <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_reg <= s_axi_awaddr;
        awHeld_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHeld_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `AXI_OKAY;
        case (awAddr_reg)
          `REG_CTRL: begin
            if (wStrb_reg[0]) begin
              ctrl_reg <= {1'b0, wData_reg[6:0]};
            end
          end
          `REG_XFER_DUTY: begin
            if (wStrb_reg[0]) begin
              duty_reg <= wData_reg[DUTY_WIDTH-1:0]; // [RULE17]
            end
          end
          `REG_LEFT_MARGIN: begin
            if (wStrb_reg[0]) margin_reg[7:0] <= wData_reg[7:0];
            if (wStrb_reg[1]) margin_reg[15:8] <= wData_reg[15:8];
          end
          `REG_LINE_LEN: begin
            if (wStrb_reg[0]) lineLen_reg[7:0] <= wData_reg[7:0];
            if (wStrb_reg[1]) lineLen_reg[15:8] <= wData_reg[15:8];
          end
          `REG_VIDEO_DATA: begin
            if (wStrb_reg[0]) videoWord_reg[7:0] <= wData_reg[7:0];
            if (wStrb_reg[1]) videoWord_reg[15:8] <= wData_reg[15:8];
            if (wStrb_reg[2]) videoWord_reg[23:16] <= wData_reg[23:16];
            if (wStrb_reg[3]) videoWord_reg[31:24] <= wData_reg[31:24];
          end
          `REG_STATUS, `REG_FUSE_PULSE: begin
            s_axi_bresp <= `AXI_OKAY;
          end
          default: begin
            s_axi_bresp <= `AXI_DECERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  always @* begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    case (s_axi_araddr)
      `REG_CTRL: rdMux = {24'h00_0000, ctrl_reg};
      `REG_STATUS: rdMux = {24'h00_0000, paperFeed, videoActive_reg,
        fuseBlowEnable, cart_reg[1], newCart_reg, fuseIntact, coverOpen,
        scannerReady};
      `REG_XFER_DUTY: rdMux = {{(32-DUTY_WIDTH){1'b0}}, duty_reg};
      `REG_LEFT_MARGIN: rdMux = {16'h0000, margin_reg};
      `REG_LINE_LEN: rdMux = {16'h0000, lineLen_reg};
      `REG_VIDEO_DATA: rdMux = videoWord_reg;
      `REG_FUSE_PULSE: rdMux = fuseCount_reg;
      default: rdHit = 1'b0;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdHit ? `AXI_OKAY : `AXI_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // New cartridge check
  // ****************************************
  // Software owns the NVRAM write; hardware waits for its done strobe
  assign coverRise = coverOpen && !coverPrev_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cart_reg <= CART_IDLE;
      coverPrev_reg <= 1'b0;
      newCart_reg <= 1'b0;
      fuseCount_reg <= 32'h0000_0000;
      fuseBlowEnable <= 1'b0;
    end else begin
      coverPrev_reg <= coverOpen;
      case (cart_reg)
        CART_IDLE: begin
          fuseBlowEnable <= 1'b0;
          if (coverRise) begin
            newCart_reg <= fuseIntact; // [RULE6]
            if (fuseIntact) begin
              cart_reg <= CART_CLEAR; // [RULE7]
            end
          end
        end
        CART_CLEAR: begin
          if (clrDoneWr) begin
            cart_reg <= CART_BLOW;
            fuseCount_reg <= FUSE_CYCLES;
            fuseBlowEnable <= 1'b1; // [RULE8]
          end
        end
        CART_BLOW: begin
          if (fuseCount_reg <= 32'h0000_0001) begin
            fuseCount_reg <= 32'h0000_0000;
            fuseBlowEnable <= 1'b0;
            cart_reg <= CART_WAIT;
          end else begin
            fuseCount_reg <= fuseCount_reg - 32'h0000_0001;
          end
        end
        CART_WAIT: begin
          fuseBlowEnable <= 1'b0;
          if (!coverOpen) cart_reg <= CART_IDLE;
        end
        default: begin
          cart_reg <= CART_IDLE;
          fuseBlowEnable <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Scan unit and video alignment
  // ****************************************
  assign syncRise = lineSync && !syncPrev_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      syncPrev_reg <= 1'b0;
      videoActive_reg <= 1'b0;
      pixCount_reg <= 16'h0000;
      mirrorMotorRun <= 1'b0;
      laserVideo <= 1'b0;
    end else begin
      syncPrev_reg <= lineSync;
      mirrorMotorRun <= ctrl_reg[`CTRL_MOTOR_RUN]; // [RULE1] [RULE16]
      if (!scannerReady || !paperFeed || !ctrl_reg[`CTRL_PRINT_GO]) begin
        videoActive_reg <= 1'b0; // [RULE15] [RULE16]
        pixCount_reg <= 16'h0000;
      end else if (syncRise) begin
        videoActive_reg <= 1'b1; // [RULE4]
        pixCount_reg <= 16'h0000;
      end else if (videoActive_reg) begin
        pixCount_reg <= pixCount_reg + 16'h0001;
        if (pixCount_reg >= margin_reg + lineLen_reg) begin
          videoActive_reg <= 1'b0;
        end
      end
      // Laser only ever sees the video bit, never a separate fire line
      laserVideo <= scannerReady && paperFeed && ctrl_reg[`CTRL_PRINT_GO] &&
        videoActive_reg && (pixCount_reg >= margin_reg) &&
        (pixCount_reg < margin_reg + lineLen_reg) &&
        videoWord_reg[pixCount_reg[4:0]]; // [RULE5] [RULE4]
    end
  end

  // ****************************************
  // High-voltage supply lines
  // ****************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      transferEnable_n <= 1'b1;
      transferLevelPwm <= 1'b1;
      mainChargeEnable <= 1'b0;
      supplyBiasEnable_n <= 1'b1;
      developerBiasEnable_n <= 1'b1;
      developerLevelHigh <= 1'b0;
    end else begin
      transferEnable_n <= !ctrl_reg[`CTRL_XFER_ON]; // [RULE9]
      transferLevelPwm <= pwmRaw; // [RULE10] [RULE11]
      mainChargeEnable <= ctrl_reg[`CTRL_MAIN_ON]; // [RULE12]
      supplyBiasEnable_n <= !(ctrl_reg[`CTRL_MAIN_ON] && ctrl_reg[`CTRL_SUPPLY_ON]); // [RULE13]
      developerBiasEnable_n <= !(ctrl_reg[`CTRL_MAIN_ON] && ctrl_reg[`CTRL_DEV_ON]); // [RULE13]
      developerLevelHigh <= ctrl_reg[`CTRL_DEV_HIGH]; // [RULE14]
    end
  end

endmodule

`default_nettype wire

// ### tb/print_engine_seq_chk.sv
// Port checker for the scan and high-voltage sequencer.
// Assumes binding onto print_engine_seq; rst is async, active high.
`timescale 1ns/1ps
`default_nettype none
module print_engine_seq_chk #(
  parameter FUSE_CYCLES = 20
) (
  input wire clk,
  input wire rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire scannerReady,
  input wire paperFeed,
  input wire laserVideo,
  input wire mainChargeEnable,
  input wire supplyBiasEnable_n,
  input wire developerBiasEnable_n,
  input wire fuseBlowEnable
);
  // ****************************************
  // Fuse pulse length, too long to unroll
  // ****************************************
  reg [31:0] blowCnt;
  always @(posedge clk or posedge rst) begin
    if (rst)
      blowCnt <= 32'h0000_0000;
    else if (fuseBlowEnable)
      blowCnt <= blowCnt + 32'h0000_0001;
    else
      blowCnt <= 32'h0000_0000;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_feed_gate: assert property (!paperFeed |=> !laserVideo)
    else $error("video while no sheet feeding");
  chk_ready_gate: assert property (!scannerReady |=> !laserVideo)
    else $error("video while scanner not ready");
  chk_supply_main: assert property (!supplyBiasEnable_n |-> mainChargeEnable)
    else $error("supply bias on without main charge");
  chk_dev_main: assert property (!developerBiasEnable_n |-> mainChargeEnable)
    else $error("developer bias on without main charge");
  chk_fuse_len: assert property ($fell(fuseBlowEnable) |-> blowCnt == FUSE_CYCLES)
    else $error("fuse pulse length wrong");
  chk_fuse_max: assert property (blowCnt <= FUSE_CYCLES)
    else $error("fuse pulse too long");
  chk_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind print_engine_seq print_engine_seq_chk #(.FUSE_CYCLES(FUSE_CYCLES)) chk (.clk, .rst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .scannerReady, .paperFeed, .laserVideo,
  .mainChargeEnable, .supplyBiasEnable_n, .developerBiasEnable_n, .fuseBlowEnable);
`default_nettype wire

// ### tb/scan_unit_model.sv
// Behavioural scan unit: spin-up delay, then one sync pulse per line.
// Assumes the motor run line from the sequencer and the system clock.
`timescale 1ns/1ps
`default_nettype none
module scan_unit_model #(
  parameter SPIN = 30,
  parameter PERIOD = 40
) (
  input wire clk,
  input wire rst,
  input wire motorRun,
  output logic scannerReady,
  output logic lineSync
);
  int spinCnt;
  int lineCnt;
  // Motor off drops ready at once, as a real mirror would lose speed
  always @(posedge clk or posedge rst) begin
    if (rst || !motorRun) begin
      spinCnt <= 0;
      lineCnt <= 0;
      scannerReady <= 1'b0;
      lineSync <= 1'b0;
    end else if (spinCnt < SPIN) begin
      spinCnt <= spinCnt + 1;
    end else begin
      scannerReady <= 1'b1;
      lineCnt <= (lineCnt == PERIOD - 1) ? 0 : lineCnt + 1;
      lineSync <= (lineCnt == 0);
    end
  end
endmodule
`default_nettype wire

// ### tb/test_print_engine_seq.sv
// Self-checking bench for the scan and high-voltage sequencer.
// Assumes the scan unit model on the far side and a 20 MHz clock.
`timescale 1ns/1ps
`include "engine_seq_regs.vh"
`default_nettype none
module test_print_engine_seq;
  localparam int FUSE = 20;
  localparam int PERIOD = 40;
  logic clk = 1'b0, rst = 1'b1, coverOpen = 1'b0, fuseIntact = 1'b0, paperFeed = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire scannerReady, lineSync, mirrorMotorRun, laserVideo, transferEnable_n;
  wire transferLevelPwm, mainChargeEnable, supplyBiasEnable_n, developerBiasEnable_n;
  wire developerLevelHigh, fuseBlowEnable;
  int error_cnt = 0;
  int comparisons = 0;
  logic [1:0] lastBresp = 2'b00;
  print_engine_seq #(.FUSE_CYCLES(FUSE)) uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .scannerReady, .lineSync, .coverOpen, .fuseIntact, .paperFeed, .mirrorMotorRun,
    .laserVideo, .transferEnable_n, .transferLevelPwm, .mainChargeEnable,
    .supplyBiasEnable_n, .developerBiasEnable_n, .developerLevelHigh, .fuseBlowEnable);
  scan_unit_model #(.SPIN(30), .PERIOD(PERIOD)) scanUnit (.clk, .rst, .motorRun(mirrorMotorRun),
    .scannerReady, .lineSync);
  initial forever #25 clk = ~clk;
  // ****************************************
  // Bus tasks and expectations
  // ****************************************
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    lastBresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Counts high cycles of video, pwm or fuse line
  task automatic countHigh(input int n, input int sel, output logic [31:0] c);
    c = 32'h0000_0000;
    repeat (n) begin
      @(posedge clk);
      c = c + (sel == 0 ? laserVideo : sel == 1 ? transferLevelPwm : fuseBlowEnable);
    end
  endtask
  function automatic logic [5:0] ctrlExp(input logic [7:0] c);
    return {c[0], ~c[1], c[2], ~(c[2] & c[3]), ~(c[2] & c[4]), c[5]};
  endfunction
  function automatic logic [31:0] pwmExp(input logic [7:0] d);
    return (d == 8'hff) ? 32'h0000_0100 : {24'h00_0000, d};
  endfunction
  task automatic stop_test;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    logic [7:0] c;
    void'($urandom(43384));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    check({mirrorMotorRun, transferEnable_n, mainChargeEnable, supplyBiasEnable_n,
      developerBiasEnable_n, transferLevelPwm, fuseBlowEnable, laserVideo}, 8'h5c);
    axiRead(`REG_XFER_DUTY, v, r);
    check(v, 32'h0000_00ff);
    axiRead(8'h1c, v, r);
    check(r, `AXI_DECERR);
    axiWrite(8'h1c, 32'h0000_0000);
    check(lastBresp, `AXI_DECERR);
    for (int i = 0; i < 10; i++) begin
      c = (i == 0) ? 8'h18 : 8'($urandom) & 8'h3f;
      axiWrite(`REG_CTRL, {24'h00_0000, c});
      repeat (2) @(posedge clk);
      check({mirrorMotorRun, transferEnable_n, mainChargeEnable, supplyBiasEnable_n,
        developerBiasEnable_n, developerLevelHigh}, ctrlExp(c));
    end
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom_range(254, 1));
      axiWrite(`REG_XFER_DUTY, {24'h00_0000, c});
      repeat (4) @(posedge clk);
      countHigh(256, 1, v);
      check(v, pwmExp(c));
    end
    axiWrite(`REG_LEFT_MARGIN, 32'h0000_0004);
    check(lastBresp, `AXI_OKAY);
    axiWrite(`REG_LINE_LEN, 32'h0000_0008);
    axiWrite(`REG_VIDEO_DATA, 32'hffff_ffff);
    axiWrite(`REG_CTRL, 32'h0000_0041);
    while (!scannerReady) @(posedge clk);
    countHigh(3 * PERIOD, 0, v);
    check(v, 32'h0000_0000);
    paperFeed <= 1'b1;
    @(posedge clk);
    while (!lineSync) @(posedge clk);
    countHigh(PERIOD, 0, v);
    check(v, 32'h0000_0008);
    paperFeed <= 1'b0;
    axiWrite(`REG_CTRL, 32'h0000_0000);
    coverOpen <= 1'b1;
    repeat (4) @(posedge clk);
    axiRead(`REG_STATUS, v, r);
    check(v[`STAT_CLEAR_REQ], 1'b0);
    check(v[`STAT_NEW_CART], 1'b0);
    coverOpen <= 1'b0;
    fuseIntact <= 1'b1;
    repeat (4) @(posedge clk);
    coverOpen <= 1'b1;
    repeat (4) @(posedge clk);
    axiRead(`REG_STATUS, v, r);
    check(v[`STAT_CLEAR_REQ], 1'b1);
    check(v[`STAT_NEW_CART], 1'b1);
    fork
      axiWrite(`REG_CTRL, 32'h0000_0080);
      countHigh(FUSE + 40, 2, v);
    join
    check(v, FUSE);
    stop_test();
  end
endmodule
`default_nettype wire
